// file: verilog/frame_dma_pkg.sv
// Shared constants and types of the frame DMA front end
`default_nettype none
package frame_dma_pkg;
   // ==========================================
   // Channel layout
   localparam int NUM_CH = 10;
   localparam int CH_W = 4;
   localparam int PRIO_W = 3;
   localparam logic [CH_W-1:0] XTR_CH_GRP0 = 4'h0;
   localparam logic [CH_W-1:0] XTR_CH_GRP1 = 4'h1;
   localparam logic [CH_W-1:0] INJ_CH_FIRST = 4'h2;
   localparam logic [CH_W-1:0] INJ_CH_LAST = 4'h9;
   localparam logic [7:0] CPU_PORT_GRP0 = 8'h35;
   localparam logic [7:0] CPU_PORT_GRP1 = 8'h36;
   localparam logic [31:0] NULL_PTR = 32'h00000000;
   // ==========================================
   // Register offsets and fields
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_ACTIVATE = 8'h04;
   localparam logic [7:0] OFS_STOP = 8'h08;
   localparam logic [7:0] OFS_STAT = 8'h0C;
   localparam logic [7:0] OFS_INTR = 8'h10;
   localparam logic [7:0] OFS_MASK = 8'h14;
   localparam logic [1:0] PAGE_CFG = 2'h1;
   localparam logic [1:0] PAGE_LLP = 2'h2;
   localparam int CFG_GRP_BIT = 4;
   localparam logic [PRIO_W-1:0] PRIO_RST = 3'h0;
   localparam logic [31:0] LLP_RST = 32'h00000000;
   // ==========================================
   // Channel status codes and engine states
   localparam logic [1:0] ST_DISABLED = 2'h0;
   localparam logic [1:0] ST_UPDATING = 2'h1;
   localparam logic [1:0] ST_ACTIVE = 2'h2;
   typedef enum logic [1:0] {ENG_IDLE, ENG_FETCH, ENG_XFER, ENG_WBACK} eng_state_t;
endpackage
`default_nettype wire

// file: verilog/channel_priority_arbiter.sv
// Strict priority pick over requesting channels
`timescale 1ns/1ps
`default_nettype none
module channel_priority_arbiter import frame_dma_pkg::*; #(
   parameter int N = NUM_CH,
   parameter int PW = PRIO_W
) (
   // Clock for checks
   input wire logic clock,
   input wire logic resetn,
   // Requests
   input wire logic [N-1:0] req,
   input wire logic [N*PW-1:0] prio,
   // Pick
   output logic valid,
   output logic [CH_W-1:0] idx
);
   logic [PW-1:0] best;
   logic [N-1:0] beaten;

   // ==========================================
   // Selection
   // highest level, larger index
   always_comb begin
      valid = 1'b0;
      idx = '0;
      best = '0;
      for (int i = 0; i < N; i++) begin
         if (req[i] && (!valid || prio[i*PW +: PW] >= best)) begin
            valid = 1'b1;
            idx = CH_W'(i);
            best = prio[i*PW +: PW];
         end
      end
   end

   // ==========================================
   // Checks
   always_comb begin
      beaten = '0;
      for (int i = 0; i < N; i++) begin
         beaten[i] = req[i] && valid && (prio[i*PW +: PW] > best ||
                     (prio[i*PW +: PW] == best && CH_W'(i) > idx));
      end
   end
   property p_best;
      @(posedge clock) disable iff (!resetn) valid |-> beaten == '0 && req[idx];
   endproperty
   a_best: assert property (p_best) else $error("arbiter pick is not the best");
   property p_only_req;
      @(posedge clock) disable iff (!resetn) valid == (|req);
   endproperty
   a_only_req: assert property (p_only_req) else $error("arbiter valid wrong");
endmodule
`default_nettype wire

// file: verilog/channel_state_ctl.sv
// Activate and stop state of one channel
`timescale 1ns/1ps
`default_nettype none
module channel_state_ctl (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Control
   input wire logic act_set,
   input wire logic stop_set,
   input wire logic in_svc,
   input wire logic end_blk,
   input wire logic null_llp,
   // State
   output logic active,
   output logic stop_pend
);
   logic active_reg, active_next, stop_reg, stop_next;

   // ==========================================
   // Next state
   always_comb begin
      active_next = active_reg;
      stop_next = stop_reg;
      if (act_set) begin
         active_next = 1'b1;
         stop_next = 1'b0;
      end else begin
         if (stop_set && active_reg) begin
            stop_next = 1'b1;
         end
         if ((stop_reg && !in_svc) || (end_blk && (stop_reg || null_llp))) begin
            active_next = 1'b0;
            stop_next = 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         active_reg <= 1'b0;
         stop_reg <= 1'b0;
      end else begin
         active_reg <= active_next;
         stop_reg <= stop_next;
      end
   end

   assign active = active_reg;
   assign stop_pend = stop_reg;

   // ==========================================
   // Checks
   property p_stop;
      @(posedge clock) disable iff (!resetn)
         stop_reg && !act_set && (!in_svc || end_blk) |=> !active_reg;
   endproperty
   a_stop: assert property (p_stop) else $error("stopped channel still active");
   property p_hold;
      @(posedge clock) disable iff (!resetn)
         active_reg && in_svc && !end_blk |=> active_reg;
   endproperty
   a_hold: assert property (p_hold) else $error("channel left mid block");
endmodule
`default_nettype wire

// file: verilog/frame_dma_engine.sv
// Frame DMA channel front end: APB registers, arbitration and block sequencing
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Frames move by themselves, block by block, following linked control blocks
// - Interrupts on frame completion and on reaching a list end
// - Channel 0 always extracts from CPU group 0, port 53
// - Channel 1 always extracts from CPU group 1, port 54
// - Channels 2 to 9 inject into the group their select bit names
// - Among ready channels the highest configured level is served first
// - Equal levels: the larger channel index wins
// - Outside manual mode, injection port ownership changes only between frames
// - Extracted frames get an internal frame header ahead of the data
// - Injected frames asking for it get their FCS recomputed
// - Manual mode bypasses arbitration and serves in requested order
// - Pointer written, then activate; engine fetches that block
// - A stop request lets the current block and status finish first
module frame_dma_engine import frame_dma_pkg::*; #(
   parameter int N = NUM_CH,
   parameter int PW = PRIO_W
) (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // APB slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   // Channel readiness from CPU ports
   input wire logic [N-1:0] ch_ready,
   // Control block fetch
   output logic fetch_req,
   output logic [31:0] fetch_addr,
   output logic [CH_W-1:0] svc_ch,
   input wire logic fetch_ack,
   input wire logic [31:0] fetch_next_llp,
   input wire logic fetch_sof,
   input wire logic fetch_eof,
   input wire logic ifh_fcs_req,
   // Data block transfer
   output logic xfer_go,
   output logic xfer_inject,
   output logic xfer_grp,
   output logic [7:0] xfer_port,
   output logic hdr_prepend,
   output logic fcs_recompute,
   input wire logic xfer_done,
   // Status write back
   output logic wb_req,
   input wire logic wb_ack,
   // Manual mode requests
   input wire logic man_req,
   input wire logic [CH_W-1:0] man_ch
);
   eng_state_t st_reg, st_next;
   logic [CH_W-1:0] sel_reg, sel_next, pick;
   logic [PW-1:0] prio_reg [N];
   logic [PW-1:0] prio_next [N];
   logic [31:0] llp_reg [N];
   logic [31:0] llp_next [N];
   logic [N-1:0] grp_reg, grp_next, act_set, stop_set, active, stop_pend;
   logic [N-1:0] in_svc, end_blk, null_llp, elig, ev_llp, ev_frm;
   logic [2*N-1:0] intr_reg, intr_next, mask_reg, mask_next;
   logic [1:0] busy_reg, busy_next;
   logic [CH_W-1:0] owner_reg [2];
   logic [CH_W-1:0] owner_next [2];
   logic manual_reg, manual_next, eof_reg, eof_next, picked, arb_valid;
   logic [CH_W-1:0] arb_ch;
   logic [N*PW-1:0] prio_flat;
   logic [31:0] prdata_reg, prdata_next, fetch_addr_reg, fetch_addr_next;
   logic pready_reg, pready_next, pslverr_reg, pslverr_next, irq_reg, irq_next;
   logic fetch_req_reg, fetch_req_next, xfer_go_reg, xfer_go_next, wb_req_reg, wb_req_next;
   logic inj_reg, inj_next, grp_o_reg, grp_o_next, hdr_reg, hdr_next, fcs_reg, fcs_next;
   logic [7:0] port_reg, port_next;
   logic wr_done, rd_done;
   logic [CH_W-1:0] ridx;

   function automatic logic grp_of(input logic [CH_W-1:0] ch, input logic [N-1:0] g);
      if (ch == XTR_CH_GRP0) begin
         return 1'b0;
      end else if (ch == XTR_CH_GRP1) begin
         return 1'b1;
      end
      return g[ch];
   endfunction

   // ==========================================
   // Channel state and arbitration
   for (genvar i = 0; i < N; i++) begin : g_ch
      channel_state_ctl u_ctl (
         .clock(clock),
         .resetn(resetn),
         .act_set(act_set[i]),
         .stop_set(stop_set[i]),
         .in_svc(in_svc[i]),
         .end_blk(end_blk[i]),
         .null_llp(null_llp[i]),
         .active(active[i]),
         .stop_pend(stop_pend[i])
      );
   end

   always_comb begin
      for (int i = 0; i < N; i++) begin
         in_svc[i] = st_reg != ENG_IDLE && sel_reg == CH_W'(i);
         null_llp[i] = llp_reg[i] == NULL_PTR;
         prio_flat[i*PW +: PW] = prio_reg[i];
         elig[i] = active[i] && ch_ready[i] && !stop_pend[i];
         if (CH_W'(i) >= INJ_CH_FIRST && busy_reg[grp_reg[i]]) begin
            elig[i] = elig[i] && owner_reg[grp_reg[i]] == CH_W'(i);
         end
      end
   end

   channel_priority_arbiter #(.N(N), .PW(PW)) u_arb (
      .clock(clock),
      .resetn(resetn),
      .req(elig),
      .prio(prio_flat),
      .valid(arb_valid),
      .idx(arb_ch)
   );

   // ==========================================
   // APB register access
   assign wr_done = psel && penable && pready_reg && pwrite;
   assign rd_done = psel && penable && pready_reg && !pwrite;
   assign ridx = paddr[5:2];

   always_comb begin
      prdata_next = '0;
      pslverr_next = 1'b0;
      pready_next = psel && penable && !pready_reg;
      manual_next = manual_reg;
      mask_next = mask_reg;
      grp_next = grp_reg;
      prio_next = prio_reg;
      act_set = '0;
      stop_set = '0;
      unique case (1'b1)
         paddr == OFS_CTRL: prdata_next = {31'h0, manual_reg};
         paddr == OFS_ACTIVATE: prdata_next = 32'(active);
         paddr == OFS_STOP: prdata_next = 32'(stop_pend);
         paddr == OFS_STAT: begin
            for (int i = 0; i < N; i++) begin
               prdata_next[2*i +: 2] = !active[i] ? ST_DISABLED :
                  (in_svc[i] && st_reg != ENG_XFER) ? ST_UPDATING : ST_ACTIVE;
            end
         end
         paddr == OFS_INTR: prdata_next = 32'(intr_reg);
         paddr == OFS_MASK: prdata_next = 32'(mask_reg);
         paddr[7:6] == PAGE_CFG && ridx <= INJ_CH_LAST && paddr[1:0] == 2'h0:
            prdata_next = {27'h0, grp_reg[ridx], 1'b0, prio_reg[ridx]};
         paddr[7:6] == PAGE_LLP && ridx <= INJ_CH_LAST && paddr[1:0] == 2'h0:
            prdata_next = llp_reg[ridx];
         default: pslverr_next = 1'b1;
      endcase
      if (wr_done) begin
         if (paddr == OFS_CTRL) begin
            manual_next = pwdata[0];
         end
         if (paddr == OFS_ACTIVATE) begin
            act_set = pwdata[N-1:0];
         end
         if (paddr == OFS_STOP) begin
            stop_set = pwdata[N-1:0];
         end
         if (paddr == OFS_MASK) begin
            mask_next = pwdata[2*N-1:0];
         end
         if (paddr[7:6] == PAGE_CFG && ridx <= INJ_CH_LAST) begin
            prio_next[ridx] = pwdata[PW-1:0];
            grp_next[ridx] = ridx >= INJ_CH_FIRST && pwdata[CFG_GRP_BIT];
         end
      end
      intr_next = (intr_reg & ~(rd_done && paddr == OFS_INTR ? '1 : '0)) | {ev_frm, ev_llp};
      irq_next = |(intr_reg & mask_reg);
   end

   // ==========================================
   // Block sequencing
   always_comb begin
      st_next = st_reg;
      sel_next = sel_reg;
      llp_next = llp_reg;
      busy_next = busy_reg;
      owner_next = owner_reg;
      eof_next = eof_reg;
      fetch_req_next = fetch_req_reg;
      fetch_addr_next = fetch_addr_reg;
      xfer_go_next = xfer_go_reg;
      wb_req_next = wb_req_reg;
      inj_next = inj_reg;
      grp_o_next = grp_o_reg;
      port_next = port_reg;
      hdr_next = 1'b0;
      fcs_next = 1'b0;
      end_blk = '0;
      ev_llp = '0;
      ev_frm = '0;
      pick = arb_ch;
      picked = !manual_reg && arb_valid;
      if (manual_reg) begin
         pick = man_ch;
         picked = man_req && man_ch <= INJ_CH_LAST && active[man_ch];
      end
      if (wr_done && paddr[7:6] == PAGE_LLP && ridx <= INJ_CH_LAST) begin
         llp_next[ridx] = pwdata;
      end
      unique case (st_reg)
         ENG_IDLE: begin
            if (picked) begin
               sel_next = pick;
               fetch_req_next = 1'b1;
               fetch_addr_next = llp_reg[pick];
               inj_next = pick >= INJ_CH_FIRST;
               grp_o_next = grp_of(pick, grp_reg);
               port_next = grp_of(pick, grp_reg) ? CPU_PORT_GRP1 : CPU_PORT_GRP0;
               st_next = ENG_FETCH;
            end
         end
         ENG_FETCH: begin
            if (fetch_ack) begin
               fetch_req_next = 1'b0;
               llp_next[sel_reg] = fetch_next_llp;
               eof_next = fetch_eof;
               xfer_go_next = 1'b1;
               if (inj_reg && fetch_sof) begin
                  busy_next[grp_o_reg] = 1'b1;
                  owner_next[grp_o_reg] = sel_reg;
               end
               hdr_next = !inj_reg && fetch_sof;
               fcs_next = inj_reg && fetch_eof && ifh_fcs_req;
               if (!inj_reg && fetch_next_llp == NULL_PTR) begin
                  ev_llp[sel_reg] = 1'b1;
               end
               st_next = ENG_XFER;
            end
         end
         ENG_XFER: begin
            if (xfer_done) begin
               xfer_go_next = 1'b0;
               wb_req_next = 1'b1;
               st_next = ENG_WBACK;
            end
         end
         ENG_WBACK: begin
            if (wb_ack) begin
               wb_req_next = 1'b0;
               end_blk[sel_reg] = 1'b1;
               ev_frm[sel_reg] = eof_reg;
               ev_llp[sel_reg] = inj_reg && llp_reg[sel_reg] == NULL_PTR;
               if (inj_reg && eof_reg && owner_reg[grp_o_reg] == sel_reg) begin
                  busy_next[grp_o_reg] = 1'b0;
               end
               st_next = ENG_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         st_reg <= ENG_IDLE;
         sel_reg <= '0;
         for (int i = 0; i < N; i++) begin
            prio_reg[i] <= PRIO_RST;
            llp_reg[i] <= LLP_RST;
         end
         grp_reg <= '0;
         intr_reg <= '0;
         mask_reg <= '0;
         busy_reg <= '0;
         owner_reg[0] <= '0;
         owner_reg[1] <= '0;
         {manual_reg, eof_reg, pready_reg, pslverr_reg, irq_reg} <= '0;
         {fetch_req_reg, xfer_go_reg, wb_req_reg, inj_reg, grp_o_reg} <= '0;
         {hdr_reg, fcs_reg} <= '0;
         prdata_reg <= '0;
         fetch_addr_reg <= '0;
         port_reg <= '0;
      end else begin
         st_reg <= st_next;
         sel_reg <= sel_next;
         prio_reg <= prio_next;
         llp_reg <= llp_next;
         grp_reg <= grp_next;
         intr_reg <= intr_next;
         mask_reg <= mask_next;
         busy_reg <= busy_next;
         owner_reg <= owner_next;
         {manual_reg, eof_reg, pready_reg, pslverr_reg, irq_reg} <=
            {manual_next, eof_next, pready_next, pslverr_next, irq_next};
         {fetch_req_reg, xfer_go_reg, wb_req_reg, inj_reg, grp_o_reg} <=
            {fetch_req_next, xfer_go_next, wb_req_next, inj_next, grp_o_next};
         {hdr_reg, fcs_reg} <= {hdr_next, fcs_next};
         prdata_reg <= prdata_next;
         fetch_addr_reg <= fetch_addr_next;
         port_reg <= port_next;
      end
   end

   assign {prdata, pready, pslverr, irq} = {prdata_reg, pready_reg, pslverr_reg, irq_reg};
   assign {fetch_req, fetch_addr, svc_ch} = {fetch_req_reg, fetch_addr_reg, sel_reg};
   assign {xfer_go, xfer_inject, xfer_grp, xfer_port} = {xfer_go_reg, inj_reg, grp_o_reg, port_reg};
   assign {hdr_prepend, fcs_recompute, wb_req} = {hdr_reg, fcs_reg, wb_req_reg};

   // ==========================================
   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   property p_xtr_grp;
      xfer_go_reg && sel_reg <= XTR_CH_GRP1 |->
         xfer_grp == sel_reg[0] && xfer_port == (sel_reg[0] ? CPU_PORT_GRP1 : CPU_PORT_GRP0);
   endproperty
   a_xtr_grp: assert property (p_xtr_grp) else $error("extraction group wrong");
   property p_inj_grp;
      xfer_go_reg && sel_reg >= INJ_CH_FIRST |-> xfer_inject && xfer_grp == grp_reg[sel_reg];
   endproperty
   a_inj_grp: assert property (p_inj_grp) else $error("injection group wrong");
   property p_owner;
      busy_reg[0] && !(st_reg == ENG_WBACK && wb_ack) |=> busy_reg[0] && $stable(owner_reg[0]);
   endproperty
   a_owner: assert property (p_owner) else $error("owner changed mid frame");
   sequence s_xtr_sof;
      st_reg == ENG_FETCH && fetch_ack && !inj_reg && fetch_sof;
   endsequence
   property p_hdr;
      s_xtr_sof |=> hdr_prepend ##1 !hdr_prepend;
   endproperty
   a_hdr: assert property (p_hdr) else $error("no frame header pulse");
   property p_fcs;
      st_reg == ENG_FETCH && fetch_ack |=> fcs_recompute == $past(inj_reg && fetch_eof && ifh_fcs_req);
   endproperty
   a_fcs: assert property (p_fcs) else $error("fcs recompute wrong");
   property p_manual;
      st_reg == ENG_IDLE && manual_reg && picked |=> sel_reg == $past(man_ch) && fetch_req;
   endproperty
   a_manual: assert property (p_manual) else $error("manual order not kept");
   sequence s_fetch_wait;
      fetch_req && fetch_addr == llp_reg[sel_reg];
   endsequence
   property p_fetch;
      st_reg == ENG_IDLE && picked |=> s_fetch_wait;
   endproperty
   a_fetch: assert property (p_fetch) else $error("fetch address wrong");
   property p_irq;
      (|(intr_reg & mask_reg)) |=> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not raised");
endmodule
`default_nettype wire

// file: verification/frame_far_side.sv
// Far side model: block fetch, data transfer and status write back
`timescale 1ns/1ps
`default_nettype none
module frame_far_side (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Requests from the engine
   input wire logic fetch_req,
   input wire logic xfer_go,
   input wire logic wb_req,
   // Block contents and answer speed chosen by the bench
   input wire logic cfg_slow,
   input wire logic [31:0] cfg_next_llp,
   input wire logic cfg_sof,
   input wire logic cfg_eof,
   input wire logic cfg_fcs,
   // Answers
   output logic fetch_ack,
   output logic [31:0] fetch_next_llp,
   output logic fetch_sof,
   output logic fetch_eof,
   output logic ifh_fcs_req,
   output logic xfer_done,
   output logic wb_ack
);
   logic [2:0] req;
   logic [2:0] seen;
   logic [2:0] ack;
   logic [2:0] cnt;
   assign req = {wb_req, xfer_go, fetch_req};
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         seen <= 3'h0;
         ack <= 3'h0;
         cnt <= 3'h0;
      end else begin
         ack <= 3'h0;
         seen <= seen & req;
         if ((req & ~seen) != 3'h0) begin
            if (cnt == (cfg_slow ? 3'h5 : 3'h0)) begin
               ack <= req & ~seen;
               seen <= req;
               cnt <= 3'h0;
            end else begin
               cnt <= cnt + 3'h1;
            end
         end
      end
   end
   assign fetch_ack = ack[0];
   assign xfer_done = ack[1];
   assign wb_ack = ack[2];
   assign fetch_next_llp = ack[0] ? cfg_next_llp : ~cfg_next_llp;
   assign fetch_sof = ack[0] ? cfg_sof : ~cfg_sof;
   assign fetch_eof = ack[0] ? cfg_eof : ~cfg_eof;
   assign ifh_fcs_req = ack[0] ? cfg_fcs : ~cfg_fcs;
endmodule
`default_nettype wire

// file: verification/frame_dma_channel_arbiter_tb.sv
// Self-checking bench of the frame DMA front end
`timescale 1ns/1ps
`default_nettype none
module frame_dma_channel_arbiter_tb import frame_dma_pkg::*;;
   logic clock, resetn, psel, penable, pwrite, pready, pslverr, irq, errv, man_req;
   logic fetch_req, fetch_ack, fetch_sof, fetch_eof, ifh_fcs_req, xfer_go, xfer_inject;
   logic xfer_grp, hdr_prepend, fcs_recompute, xfer_done, wb_req, wb_ack;
   logic cfg_slow, cfg_sof, cfg_eof, cfg_fcs;
   logic [7:0] paddr, xfer_port;
   logic [31:0] pwdata, prdata, fetch_addr, fetch_next_llp, cfg_next_llp, rdv;
   logic [3:0] svc_ch, man_ch;
   logic [9:0] ch_ready;
   int n_errors = 0;
   int num_checks = 0;
   int cyc = 0;
   frame_dma_engine DUT (.clock, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata,
      .prdata, .pready, .pslverr, .irq, .ch_ready, .fetch_req, .fetch_addr, .svc_ch,
      .fetch_ack, .fetch_next_llp, .fetch_sof, .fetch_eof, .ifh_fcs_req, .xfer_go,
      .xfer_inject, .xfer_grp, .xfer_port, .hdr_prepend, .fcs_recompute, .xfer_done,
      .wb_req, .wb_ack, .man_req, .man_ch);
   frame_far_side far (.clock, .resetn, .fetch_req, .xfer_go, .wb_req, .cfg_slow,
      .cfg_next_llp, .cfg_sof, .cfg_eof, .cfg_fcs, .fetch_ack, .fetch_next_llp,
      .fetch_sof, .fetch_eof, .ifh_fcs_req, .xfer_done, .wb_ack);
   // ==========================================
   // Shared tasks
   task automatic chk(input logic ok, input string m);
      num_checks++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("ERROR at %0t: %s", $time, m);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic setup(input logic [3:0] ch, input logic [31:0] cfg, input logic [31:0] llp);
      apb(1'b1, 8'h40 + {ch, 2'b00}, cfg);
      apb(1'b1, 8'h80 + {ch, 2'b00}, llp);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic pulse(input logic [3:0] ch);
      @(posedge clock);
      man_ch <= ch; man_req <= 1'b1;
      @(posedge clock);
      man_req <= 1'b0;
   endtask
   task automatic serve(input logic [3:0] ch, input logic g, input logic [31:0] a,
         input logic s, input logic e, input logic f, input logic [31:0] nl);
      logic inj;
      inj = (ch >= INJ_CH_FIRST);
      @(posedge clock);
      cfg_sof <= s; cfg_eof <= e; cfg_fcs <= f; cfg_next_llp <= nl;
      do @(negedge clock); while (fetch_req !== 1'b1);
      chk(svc_ch === ch && fetch_addr === a, "wrong channel or block");
      do @(negedge clock); while (xfer_go !== 1'b1);
      chk(xfer_inject === inj && xfer_grp === g, "wrong direction");
      chk(xfer_port === (g ? CPU_PORT_GRP1 : CPU_PORT_GRP0), "wrong port");
      chk(hdr_prepend === (!inj && s), "header pulse");
      chk(fcs_recompute === (inj && e && f), "checksum pulse");
      do @(negedge clock); while (wb_req !== 1'b1);
      do @(negedge clock); while (wb_req !== 1'b0);
   endtask
   // ==========================================
   // Scenarios
   task automatic t_regs();
      apb(1'b0, OFS_CTRL, 32'h0);
      chk(rdv === 32'h0 && errv === 1'b0, "control reset");
      apb(1'b0, 8'h8C, 32'h0);
      chk(rdv === LLP_RST, "pointer reset");
      apb(1'b0, 8'h30, 32'h0);
      chk(errv === 1'b1 && rdv === 32'h0, "unmapped");
      $display("regs done");
   endtask
   task automatic t_xtr();
      setup(4'h0, 32'h0, 32'h100);
      setup(4'h1, 32'h0, 32'h200);
      ch_ready <= 10'h003;
      apb(1'b1, OFS_ACTIVATE, 32'h3);
      serve(4'h1, 1'b1, 32'h200, 1'b1, 1'b1, 1'b0, NULL_PTR);
      serve(4'h0, 1'b0, 32'h100, 1'b1, 1'b0, 1'b0, NULL_PTR);
      wt(2);
      chk(irq === 1'b0, "masked irq");
      apb(1'b1, OFS_MASK, 32'h3);
      wt(2);
      chk(irq === 1'b1, "irq");
      apb(1'b0, OFS_INTR, 32'h0);
      chk(rdv[1:0] === 2'h3, "list end events");
      wt(2);
      chk(irq === 1'b0, "read clears");
      $display("extraction done");
   endtask
   task automatic t_inj();
      setup(4'h5, 32'h12, 32'h300);
      setup(4'h3, 32'h05, 32'h400);
      ch_ready <= 10'h028;
      apb(1'b1, OFS_ACTIVATE, 32'h28);
      serve(4'h3, 1'b0, 32'h400, 1'b1, 1'b1, 1'b1, NULL_PTR);
      serve(4'h5, 1'b1, 32'h300, 1'b1, 1'b1, 1'b0, NULL_PTR);
      $display("injection done");
   endtask
   task automatic t_own();
      setup(4'h3, 32'h01, 32'h500);
      setup(4'h7, 32'h05, 32'h600);
      ch_ready <= 10'h008;
      apb(1'b1, OFS_ACTIVATE, 32'h88);
      fork
         serve(4'h3, 1'b0, 32'h500, 1'b1, 1'b0, 1'b0, 32'h504);
         begin
            @(posedge fetch_ack);
            ch_ready <= 10'h088;
         end
      join
      serve(4'h3, 1'b0, 32'h504, 1'b0, 1'b1, 1'b0, NULL_PTR);
      serve(4'h7, 1'b0, 32'h600, 1'b1, 1'b1, 1'b0, NULL_PTR);
      $display("ownership done");
   endtask
   task automatic t_stop();
      cfg_slow <= 1'b1;
      setup(4'h4, 32'h0, 32'h700);
      ch_ready <= 10'h010;
      apb(1'b1, OFS_ACTIVATE, 32'h10);
      apb(1'b1, OFS_STOP, 32'h10);
      serve(4'h4, 1'b0, 32'h700, 1'b1, 1'b1, 1'b0, 32'h800);
      apb(1'b0, OFS_STAT, 32'h0);
      chk(rdv[9:8] === ST_DISABLED, "stopped");
      wt(20);
      chk(fetch_req === 1'b0, "no fetch after stop");
      cfg_slow <= 1'b0;
      $display("stop done");
   endtask
   task automatic t_man();
      apb(1'b1, OFS_CTRL, 32'h1);
      setup(4'h6, 32'h0, 32'h900);
      setup(4'h8, 32'h0, 32'hA00);
      ch_ready <= 10'h140;
      apb(1'b1, OFS_ACTIVATE, 32'h140);
      wt(5);
      chk(fetch_req === 1'b0, "no pick in manual");
      apb(1'b0, OFS_STAT, 32'h0);
      chk(rdv[13:12] === ST_ACTIVE && rdv[17:16] === ST_ACTIVE, "active state");
      pulse(4'h6);
      serve(4'h6, 1'b0, 32'h900, 1'b1, 1'b1, 1'b0, NULL_PTR);
      pulse(4'h8);
      serve(4'h8, 1'b0, 32'hA00, 1'b1, 1'b1, 1'b0, NULL_PTR);
      apb(1'b1, OFS_CTRL, 32'h0);
      $display("manual done");
   endtask
   task automatic results();
      $display("Checks %0d, mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // ==========================================
   // Clock, timeout and main sequence
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         $display("ERROR at %0t: timeout", $time);
         results();
      end
   end
   initial begin
      resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
      pwdata = 32'h0; ch_ready = 10'h000; man_req = 1'b0; man_ch = 4'h0;
      cfg_slow = 1'b0; cfg_sof = 1'b0; cfg_eof = 1'b0; cfg_fcs = 1'b0; cfg_next_llp = 32'h0;
      repeat (5) @(posedge clock);
      resetn <= 1'b1;
      t_regs();
      t_xtr();
      t_inj();
      t_own();
      t_stop();
      t_man();
      results();
   end
endmodule
`default_nettype wire
